// File: dtfm_trip_mgr.sv
`timescale 1ns/1ps
`default_nettype none
module dtfm_trip_mgr #(
    parameter longint LOCK_BASE = dtfm_pkg::LOCK_BASE_CYC
) (
    // clock and power-up reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // fault condition pins
    input  wire dtfm_pkg::dtfm_fault_t  faults,
    // reset request pins
    input  wire dtfm_pkg::dtfm_rst_src_t rst_src,
    // status
    output logic [7:0]                  fault_code,
    output logic                        tripped,
    output logic                        reset_locked,
    output logic                        start_inhibit,
    output logic [2:0]                  lock_count
);

    // synchronised pins
    dtfm_pkg::dtfm_fault_t   flt_s;      // faults after two flops
    dtfm_pkg::dtfm_rst_src_t src_s;      // reset sources after two flops

    dtfm_sync #(.W(dtfm_pkg::NFAULT)) u_sync_flt (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (faults),
        .q     (flt_s)
    );

    dtfm_sync #(.W(4)) u_sync_src (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (rst_src),
        .q     (src_s)
    );

    // priority encode: first listed condition wins a same-cycle tie
    logic [7:0] code_nxt;        // code of highest priority active fault
    logic       lockable_nxt;    // that fault needs a lockout

    always_comb begin
        code_nxt     = dtfm_pkg::FC_NONE;
        lockable_nxt = 1'b0;
        if (flt_s.out_oc) begin
            code_nxt     = dtfm_pkg::FC_OUT_OC;
            lockable_nxt = 1'b1;
        end else if (flt_s.short_oc) begin
            code_nxt     = dtfm_pkg::FC_SHORT_OC;
            lockable_nxt = 1'b1;
        end else if (flt_s.mot_ol) begin
            code_nxt     = dtfm_pkg::FC_MOT_OL;
            lockable_nxt = 1'b1;
        end else if (flt_s.brk_oc) begin
            code_nxt = dtfm_pkg::FC_BRK_OC;
        end else if (flt_s.brk_ol) begin
            code_nxt = dtfm_pkg::FC_BRK_OL;
        end else if (flt_s.bus_ov) begin
            code_nxt = dtfm_pkg::FC_BUS_OV;
        end else if (flt_s.bus_uv) begin
            code_nxt = dtfm_pkg::FC_BUS_UV;
        end else if (flt_s.hs_ot) begin
            code_nxt = dtfm_pkg::FC_HS_OT;
        end else if (flt_s.under_t) begin
            code_nxt = dtfm_pkg::FC_UNDER_T;
        end else if (flt_s.ext_trip_open) begin
            code_nxt = dtfm_pkg::FC_EXT_TRIP;
        end else if (flt_s.net_loss) begin
            code_nxt = dtfm_pkg::FC_NET_LOSS;
        end else if (flt_s.ripple) begin
            code_nxt = dtfm_pkg::FC_RIPPLE;
        end else if (flt_s.ph_loss) begin
            code_nxt = dtfm_pkg::FC_PH_LOSS;
        end else if (flt_s.hs_therm) begin
            code_nxt = dtfm_pkg::FC_HS_THERM;
        end else if (flt_s.mem_io) begin
            code_nxt = dtfm_pkg::FC_MEM_IO;
        end else if (flt_s.sig_loss) begin
            code_nxt = dtfm_pkg::FC_SIG_LOSS;
        end else if (flt_s.mem_dsp) begin
            code_nxt = dtfm_pkg::FC_MEM_DSP;
        end else if (flt_s.mot_ptc) begin
            code_nxt = dtfm_pkg::FC_MOT_PTC;
        end else if (flt_s.int_ot) begin
            code_nxt = dtfm_pkg::FC_INT_OT;
        end else if (flt_s.out_fault) begin
            code_nxt = dtfm_pkg::FC_OUT_FAULT;
        end else if (flt_s.tune_bad) begin
            code_nxt = dtfm_pkg::FC_TUNE;
        end else if (flt_s.mb_loss) begin
            code_nxt = dtfm_pkg::FC_MB_LOSS;
        end else if (flt_s.can_loss) begin
            code_nxt = dtfm_pkg::FC_CAN_LOSS;
        end
    end

    // edge detection on reset sources
    logic enable_d_r;            // previous enable level
    logic ctrl_bit_d_r;          // previous control-word reset bit
    logic stop_d_r;              // previous stop key level

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_d_r   <= 1'b0;
            ctrl_bit_d_r <= 1'b0;
            stop_d_r     <= 1'b0;
        end else begin
            enable_d_r   <= src_s.enable;
            ctrl_bit_d_r <= src_s.ctrl_reset_bit;
            stop_d_r     <= src_s.stop_key;
        end
    end

    // enable removed and reapplied shows as a rising edge
    logic en_rise;               // enable reapplied
    logic key_press;             // stop/reset key pressed
    logic bus_rise;              // control word reset bit 0 to 1
    logic reset_req;             // any reset source this cycle

    assign en_rise   = src_s.enable & ~enable_d_r;
    assign key_press = src_s.stop_key & ~stop_d_r;
    // only honoured while the fieldbus is in use
    assign bus_rise  = src_s.fieldbus_on & src_s.ctrl_reset_bit
                     & ~ctrl_bit_d_r;
    assign reset_req = en_rise | key_press | bus_rise;

    // state machine of the manager
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LOCKED = 2'b01,
        ST_TRIP   = 2'b10
    } dtfm_state_t;

    dtfm_state_t state_r;        // current state
    logic [7:0]  code_r;         // latched code
    logic [38:0] lock_cnt_r;     // lockout countdown in cycles
    logic [2:0]  step_r;         // lockout trips so far, saturating
    logic [38:0] lock_load;      // delay for the next lockout

    // delay doubles per lockout trip; step 5 and later stay at 64 s
    assign lock_load = 39'(LOCK_BASE) << step_r;

    // code latch and state; reset only clears a trip already latched
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            code_r  <= dtfm_pkg::FC_NONE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (code_nxt != dtfm_pkg::FC_NONE) begin
                        code_r  <= code_nxt;
                        state_r <= lockable_nxt ? ST_LOCKED : ST_TRIP;
                    end
                end
                ST_LOCKED: begin
                    // resets ignored until the countdown ends
                    if (lock_cnt_r == 39'h0) begin
                        state_r <= ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (reset_req) begin
                        state_r <= ST_IDLE;
                        code_r  <= dtfm_pkg::FC_NONE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    code_r  <= dtfm_pkg::FC_NONE;
                end
            endcase
        end
    end

    // lockout counter: loaded when a lockable trip latches
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_r <= 39'h0;
        end else if (state_r == ST_IDLE && lockable_nxt) begin
            lock_cnt_r <= lock_load - 39'h1;
        end else if (lock_cnt_r != 39'h0) begin
            lock_cnt_r <= lock_cnt_r - 39'h1;
        end
    end

    // trip count survives fault resets, cleared only at power-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_r <= 3'h0;
        end else if (state_r == ST_IDLE && lockable_nxt &&
                     step_r != dtfm_pkg::LOCK_STEP_MAX) begin
            step_r <= step_r + 3'h1;
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_code    <= dtfm_pkg::FC_NONE;
            tripped       <= 1'b0;
            reset_locked  <= 1'b0;
            start_inhibit <= 1'b0;
            lock_count    <= 3'h0;
        end else begin
            fault_code    <= code_r;
            tripped       <= (state_r != ST_IDLE);
            reset_locked  <= (state_r == ST_LOCKED);
            // cold drive may not start even after the trip clears
            start_inhibit <= (state_r != ST_IDLE) | flt_s.under_t;
            lock_count    <= step_r;
        end
    end

    // checks
    sequence s_lock_trip;
        state_r == ST_IDLE && lockable_nxt;
    endsequence

    sequence s_first_lock;
        s_lock_trip ##0 step_r == 3'h0;
    endsequence

    sequence s_last_lock;
        s_lock_trip ##0 step_r == dtfm_pkg::LOCK_STEP_MAX;
    endsequence

    chk_idle_code_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_IDLE |-> code_r == dtfm_pkg::FC_NONE)
        else $error("idle with non-zero code");

    chk_code_holds: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r != ST_IDLE && $past(state_r) != ST_IDLE
        |-> $stable(code_r))
        else $error("latched code changed during trip");

    chk_lock_no_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_LOCKED |=> state_r != ST_IDLE)
        else $error("reset accepted during lockout");

    chk_first_delay: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_first_lock |=> lock_cnt_r == 39'(LOCK_BASE) - 39'h1)
        else $error("first lockout delay wrong");

    chk_step_sat: assert property (
        @(posedge clk) disable iff (!rst_b)
        step_r <= dtfm_pkg::LOCK_STEP_MAX)
        else $error("trip step above saturation");

    chk_step_kept: assert property (
        @(posedge clk) disable iff (!rst_b)
        !(state_r == ST_IDLE && lockable_nxt) |=> $stable(step_r))
        else $error("trip step changed without trip");

    chk_out_oc_code: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_IDLE && flt_s.out_oc
        |=> code_r == dtfm_pkg::FC_OUT_OC && state_r == ST_LOCKED)
        else $error("output overcurrent not latched");

    chk_bus_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_TRIP && bus_rise |=> state_r == ST_IDLE ##1
        !tripped)
        else $error("control word reset not honoured");

    chk_key_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_TRIP && key_press |=> code_r == dtfm_pkg::FC_NONE)
        else $error("stop key reset not honoured");

    chk_lock_holds: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_LOCKED && lock_cnt_r != 39'h0
        |=> state_r == ST_LOCKED)
        else $error("lockout left before countdown end");

    chk_lock_ends: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_LOCKED && lock_cnt_r == 39'h0
        |=> state_r == ST_TRIP ##1 !reset_locked)
        else $error("lockout did not end at zero");

    chk_locked_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_LOCKED |=> reset_locked && tripped)
        else $error("lockout not shown on outputs");

    chk_later_delay: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_last_lock |=> lock_cnt_r ==
        (39'(LOCK_BASE) << dtfm_pkg::LOCK_STEP_MAX) - 39'h1)
        else $error("longest lockout delay wrong");

    chk_step_count: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_lock_trip ##0 step_r != dtfm_pkg::LOCK_STEP_MAX
        |=> step_r == $past(step_r) + 3'h1)
        else $error("lockable trip not counted");

    chk_en_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_TRIP && en_rise |=> state_r == ST_IDLE)
        else $error("enable reapplied did not clear trip");

    chk_bus_off_ignored: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_r == ST_TRIP && !src_s.fieldbus_on && !en_rise && !key_press
        |=> state_r == ST_TRIP)
        else $error("reset taken with fieldbus off");

    chk_cold_inhibit: assert property (
        @(posedge clk) disable iff (!rst_b)
        flt_s.under_t |=> start_inhibit)
        else $error("start allowed while too cold");

endmodule : dtfm_trip_mgr
`default_nettype wire

// File: dtfm_pkg.sv
package dtfm_pkg;

    // fault code values (hexadecimal, as shown on the display)
    localparam logic [7:0] FC_NONE      = 8'h00;
    localparam logic [7:0] FC_BRK_OC    = 8'h01;
    localparam logic [7:0] FC_BRK_OL    = 8'h02;
    localparam logic [7:0] FC_OUT_OC    = 8'h03;
    localparam logic [7:0] FC_MOT_OL    = 8'h04;
    localparam logic [7:0] FC_BUS_OV    = 8'h06;
    localparam logic [7:0] FC_BUS_UV    = 8'h07;
    localparam logic [7:0] FC_HS_OT     = 8'h08;
    localparam logic [7:0] FC_UNDER_T   = 8'h09;
    localparam logic [7:0] FC_EXT_TRIP  = 8'h0b;
    localparam logic [7:0] FC_NET_LOSS  = 8'h0c;
    localparam logic [7:0] FC_RIPPLE    = 8'h0d;
    localparam logic [7:0] FC_PH_LOSS   = 8'h0e;
    localparam logic [7:0] FC_SHORT_OC  = 8'h0f;
    localparam logic [7:0] FC_HS_THERM  = 8'h10;
    localparam logic [7:0] FC_MEM_IO    = 8'h11;
    localparam logic [7:0] FC_SIG_LOSS  = 8'h12;
    localparam logic [7:0] FC_MEM_DSP   = 8'h13;
    localparam logic [7:0] FC_MOT_PTC   = 8'h15;
    localparam logic [7:0] FC_INT_OT    = 8'h17;
    localparam logic [7:0] FC_OUT_FAULT = 8'h1a;
    localparam logic [7:0] FC_TUNE      = 8'h29;
    localparam logic [7:0] FC_MB_LOSS   = 8'h32;
    localparam logic [7:0] FC_CAN_LOSS  = 8'h33;

    // number of fault inputs
    localparam int NFAULT = 23;

    // timing
    localparam longint CLK_HZ        = 64'd125_000_000;
    localparam longint LOCK_BASE_S   = 64'd2;
    localparam longint LOCK_BASE_CYC = LOCK_BASE_S * CLK_HZ;
    localparam logic [2:0] LOCK_STEP_MAX = 3'h5;

    // raw fault condition levels, one bit per condition
    typedef struct packed {
        logic brk_oc;
        logic brk_ol;
        logic out_oc;
        logic mot_ol;
        logic bus_ov;
        logic bus_uv;
        logic hs_ot;
        logic under_t;
        logic ext_trip_open;
        logic net_loss;
        logic ripple;
        logic ph_loss;
        logic short_oc;
        logic hs_therm;
        logic mem_io;
        logic sig_loss;
        logic mem_dsp;
        logic mot_ptc;
        logic int_ot;
        logic out_fault;
        logic tune_bad;
        logic mb_loss;
        logic can_loss;
    } dtfm_fault_t;

    // reset request levels
    typedef struct packed {
        logic enable;
        logic stop_key;
        logic ctrl_reset_bit;
        logic fieldbus_on;
    } dtfm_rst_src_t;

endpackage : dtfm_pkg

// File: dtfm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bus of pin levels
module dtfm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;       // first stage, read only by q

    // plain two-stage capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : dtfm_sync
`default_nettype wire

// File: dtfm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// keypad, enable terminal and fieldbus master seen from the manager
module dtfm_host_model (
    // clock
    input  wire logic                   clk,
    // request from the bench
    input  wire logic                   go,       // start one request
    input  wire logic [1:0]             kind,     // 0 stop, 1 enable, 2 word
    input  wire logic [3:0]             hold,     // press length, cycles
    input  wire logic                   fb_on,    // fieldbus in use
    // pins toward the manager
    output var dtfm_pkg::dtfm_rst_src_t rst_src
);
    logic [3:0] left_r = 4'h0;                    // cycles of press left
    logic [1:0] kind_r = 2'h0;                    // request being acted

    // request timer, changes just after the rising edge
    always @(posedge clk) begin
        if (go && left_r == 4'h0) begin
            left_r <= hold;
            kind_r <= kind;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end

    // enable idles high, dropped then reapplied as one request
    assign rst_src.enable = !(left_r != 4'h0 && kind_r == 2'h1);
    // stop key held for the press length
    assign rst_src.stop_key = (left_r != 4'h0 && kind_r == 2'h0);
    // reset bit goes 0 to 1 then back, a slow master holds it longer
    assign rst_src.ctrl_reset_bit = (left_r != 4'h0 && kind_r == 2'h2);
    assign rst_src.fieldbus_on = fb_on;
endmodule : dtfm_host_model
`default_nettype wire

// File: test_drive_trip_fault_manager.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    bad_count++; $display("ERROR at %0t: got %0h expected %0h", \
    $time, (got), (exp)); end end
module test_drive_trip_fault_manager;
    localparam longint LB = 32;                   // short lockout base
    // code per fault bit, struct order msb first
    localparam logic [7:0] CODES [23] = '{
        8'h01, 8'h02, 8'h03, 8'h04,
        8'h06, 8'h07, 8'h08, 8'h09,
        8'h0b, 8'h0c, 8'h0d, 8'h0e,
        8'h0f, 8'h10, 8'h11, 8'h12,
        8'h13, 8'h15, 8'h17, 8'h1a,
        8'h29, 8'h32, 8'h33};
    logic                    clk;                 // bench clock
    logic                    rst_b;               // power-up reset
    dtfm_pkg::dtfm_fault_t   faults;              // fault levels
    dtfm_pkg::dtfm_rst_src_t rst_src;             // reset sources
    logic [7:0]              fault_code;
    logic                    tripped;
    logic                    reset_locked;
    logic                    start_inhibit;
    logic [2:0]              lock_count;
    logic                    go;                  // model request strobe
    logic [1:0]              kind;                // model request type
    logic [3:0]              hold;                // model press length
    logic                    fb_on;               // fieldbus in use
    logic [31:0]             rnd;                 // random state
    logic [7:0]              prev_code = 8'h00;   // last seen code
    logic [7:0]              exp_code;            // note taken off queue
    logic [7:0]              exp_q [$];           // expected code changes
    int                      bad_count = 0;
    int                      n_checks = 0;
    int                      cyc = 0;             // cycles since start
    int                      lockn = 0;           // lockable trips so far

    dtfm_trip_mgr #(.LOCK_BASE(LB)) i_dut (
        .clk(clk), .rst_b(rst_b), .faults(faults), .rst_src(rst_src),
        .fault_code(fault_code), .tripped(tripped),
        .reset_locked(reset_locked), .start_inhibit(start_inhibit),
        .lock_count(lock_count));

    dtfm_host_model i_host (
        .clk(clk), .go(go), .kind(kind), .hold(hold), .fb_on(fb_on),
        .rst_src(rst_src));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // simple shift-register random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // verdict and end of run, reached from main flow or timeout
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // each code change must match the oldest note
    always @(negedge clk) begin
        if (fault_code !== prev_code) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("ERROR at %0t: unexpected code change", $time);
            end else begin
                exp_code = exp_q.pop_front();
                `CHK(fault_code, exp_code)
            end
        end
        prev_code <= fault_code;
    end

    // hang guard, well above the longest lockout chain
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("ERROR at %0t: timeout", $time);
            give_verdict();
        end
    end

    // one request through the host model, then let it settle
    task automatic send(input logic [1:0] k);
        rnd = lfsr_next(rnd);
        kind = k;
        hold = {1'b0, rnd[2:0]} + 4'h1;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (18) @(negedge clk);
    endtask : send

    // bounded wait for a trip to show
    task automatic wait_trip();
        for (int k = 0; k < 20 && tripped !== 1'b1; k++) @(negedge clk);
        `CHK(tripped, 1'b1)
    endtask : wait_trip

    // trip on fault bit i, try a second fault, then clear it
    task automatic run_fault(input int i);
        logic [22:0] b;
        int          t0;
        int          sel;
        int          ex;
        b = 23'h1 << (22 - i);
        exp_q.push_back(CODES[i]);
        faults = b;
        wait_trip();
        t0 = cyc;
        `CHK(start_inhibit, 1'b1)
        if (i == 2 || i == 3 || i == 12) begin
            // stop pressed at once must be lost in the lockout
            kind = 2'h0;
            hold = 4'h1;
            go = 1'b1;
            @(negedge clk);
            go = 1'b0;
            for (int k = 0; k < 4000 && reset_locked === 1'b1; k++)
                @(negedge clk);
            ex = int'(LB) << (lockn > 5 ? 5 : lockn);
            `CHK(((cyc - t0) >= ex - 3) && ((cyc - t0) <= ex + 3), 1'b1)
            `CHK(tripped, 1'b1)
            lockn++;
            `CHK(lock_count, 3'((lockn > 5) ? 5 : lockn))
        end else begin
            `CHK(reset_locked, 1'b0)
        end
        // a later fault while tripped must not replace the code
        rnd = lfsr_next(rnd);
        faults = b | (23'h1 << (rnd % 23));
        repeat (6) @(negedge clk);
        faults = '0;
        repeat (4) @(negedge clk);
        sel = i % 3;
        if (sel == 2) begin
            // word bit is ignored with the fieldbus off
            fb_on = 1'b0;
            send(2'h2);
            `CHK(tripped, 1'b1)
            fb_on = 1'b1;
        end
        exp_q.push_back(8'h00);
        send(sel[1:0]);
        `CHK(tripped, 1'b0)
        `CHK(start_inhibit, 1'b0)
    endtask : run_fault

    // main sequence
    initial begin
        rst_b = 1'b0;
        faults = '0;
        go = 1'b0;
        kind = 2'h0;
        hold = 4'h2;
        fb_on = 1'b1;
        rnd = 32'h17a3;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(fault_code, 8'h00)
        for (int i = 0; i < 23; i++) run_fault(i);
        // more overcurrent trips walk the lockout to its ceiling
        repeat (4) run_fault(2);
        `CHK(lock_count, 3'h5)
        // power cycle clears a trip and the trip count
        exp_q.push_back(8'h01);
        faults = 23'h1 << 22;
        wait_trip();
        faults = '0;
        exp_q.push_back(8'h00);
        rst_b = 1'b0;
        @(negedge clk);
        `CHK(fault_code, 8'h00)
        `CHK(lock_count, 3'h0)
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(tripped, 1'b0)
        `CHK(exp_q.size(), 0)
        give_verdict();
    end
endmodule : test_drive_trip_fault_manager
`default_nettype wire
